// ---- src/ltf_pkg.sv ----
// Constants and types for the logic, trap and flags execution slice
package ltf_pkg;
  localparam logic [7:0] OP_MASK_FIRST  = 8'h72;
  localparam logic [7:0] OP_MASK_LAST   = 8'h77;
  localparam logic [7:0] OP_MASK_EXT_ER = 8'h78;
  localparam logic [7:0] OP_MASK_EXT_IM = 8'h79;
  localparam logic [7:0] OP_XOR_FIRST   = 8'hB2;
  localparam logic [7:0] OP_XOR_LAST    = 8'hB7;
  localparam logic [7:0] OP_XOR_EXT_ER  = 8'hB8;
  localparam logic [7:0] OP_XOR_EXT_IM  = 8'hB9;
  localparam logic [7:0] OP_TRAP        = 8'hF2;
  localparam logic [7:0] OP_INT_RETURN  = 8'hBF;
  localparam int         TRAP_CYCLES   = 6;
  localparam int         EXT_FETCH     = 4;
  localparam logic [15:0] SP_STEP_PC   = 16'h0002;
  localparam logic [15:0] SP_STEP_FL   = 16'h0001;
  localparam logic [15:0] SP_STEP_ONE  = 16'h0001;
  // Flag bit positions
  localparam int FLG_C  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_S  = 5;
  localparam int FLG_V  = 4;
  localparam int FLG_D  = 3;
  localparam int FLG_H  = 2;
  localparam int FLG_U2 = 1;
  localparam int FLG_U1 = 0;
  localparam logic [5:0] STATUS_RST    = 6'h00;
  localparam logic [3:0] CC_C = 4'h7;
  localparam logic [3:0] CC_Z = 4'h6;
  localparam logic [3:0] CC_S = 4'h5;
  localparam logic [3:0] CC_V = 4'h4;
  localparam logic [2:0] TS_ZERO = 3'h0;
  localparam logic [2:0] TS_LAST = 3'h5;
  typedef enum logic [2:0] {
    LTF_IDLE, LTF_PUSH_LO, LTF_PUSH_HI, LTF_PUSH_FL, LTF_VEC_LO, LTF_VEC_HI, LTF_POP_FL
  } ltf_state_e;
endpackage

// ---- src/ltf_alu.sv ----
// Logic unit for test-under-mask and exclusive-or
`timescale 1ns/1ps
`default_nettype none
module ltf_alu (
  input  wire logic [7:0] dst_val,
  input  wire logic [7:0] src_val,
  input  wire logic       do_xor,
  output logic [7:0]      result,
  output logic            res_zero,
  output logic            res_sign
);
  always_comb begin
    result   = do_xor ? (dst_val ^ src_val) : (dst_val & src_val);
    res_zero = (result == 8'h00);
    res_sign = result[7];
  end
endmodule
`default_nettype wire

// ---- src/ltf_core.sv ----
// Execution slice: test-under-mask, exclusive-or, software vector call and flags register
//
// Operation
// RULE_01 - Test-under-mask 72..77 ANDs operands, no writeback; sets Z,S, clears V.
// RULE_02 - Extended test-under-mask 78,79: same non-writing AND, four fetch cycles.
// RULE_03 - XOR B2..B7 writes dst^src back; Z,S set, V cleared, C,D,H kept.
// RULE_04 - Extended XOR B8,B9 stores result with the same flag effects.
// RULE_05 - Vector call 8'hF2: SP minus two, push PC; six execution cycles.
// RULE_06 - Then SP minus one, push flags, load PC from vector; flags unchanged.
// RULE_07 - Flags hold status of the latest arithmetic or logical operation.
// RULE_08 - Six status flags kept apart from two user bits.
// RULE_09 - Carry, overflow, zero and sign selectable as jump conditions.
// RULE_10 - Half-carry and decimal flags never selectable as jump conditions.
// RULE_11 - User bits change only by explicit user-flag writes; the code also reloads them from the stacked flags at interrupt return.
// RULE_12 - User bits never offered as jump conditions.
// RULE_13 - User bits have no reset value and reset leaves them alone.
// RULE_14 - Interrupt, vector call and illegal trap all push the flags.
// RULE_15 - Interrupt return reloads flags from the stacked value.
// RULE_16 - Flags are eight bits at fixed positions.
`timescale 1ns/1ps
`default_nettype none
module ltf_core
  import ltf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_code,
  input  wire logic [7:0]  op_dst,
  input  wire logic [7:0]  op_src,
  input  wire logic        irq_take,
  input  wire logic        illegal_take,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] vec_addr,
  input  wire logic        alu_flag_we,
  input  wire logic [5:0]  alu_flag_val,
  input  wire logic        user_flag_we,
  input  wire logic [1:0]  user_flag_val,
  input  wire logic [3:0]  cond_sel,
  input  wire logic [7:0]  mem_rdata,
  output logic             busy,
  output logic [7:0]       wb_data,
  output logic             wb_en,
  output logic [2:0]       fetch_len,
  output logic             mem_we,
  output logic             mem_re,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic [15:0]      sp_out,
  output logic             pc_load,
  output logic [15:0]      pc_next,
  output logic [7:0]       flags,
  output logic             cond_true
);
  import ltf_pkg::*;

  function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction

  logic [5:0]  status_ff, nxt_status;
  logic [1:0]  user_ff, nxt_user;
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] pc_sv_ff, nxt_pc_sv;
  logic [15:0] vec_ff, nxt_vec;
  logic [7:0]  vlo_ff, nxt_vlo;
  logic [2:0]  tcnt_ff, nxt_tcnt;
  ltf_state_e  st_ff, nxt_st;
  logic [7:0]  wb_ff, nxt_wb;
  logic        wbe_ff, nxt_wbe;
  logic [7:0]  alu_res;
  logic        alu_z, alu_s;
  logic        is_mask, is_xor, is_ext;

  // Internal status order: C Z S V D H
  assign flags = {status_ff, user_ff}; // RULE_16
  assign sp_out = sp_ff;
  assign busy = (st_ff != LTF_IDLE);
  assign wb_data = wb_ff;
  assign wb_en = wbe_ff;

  always_comb begin
    is_mask = in_range(op_code, OP_MASK_FIRST, OP_MASK_EXT_IM);
    is_xor  = in_range(op_code, OP_XOR_FIRST, OP_XOR_EXT_IM);
    is_ext  = (op_code == OP_MASK_EXT_ER) || (op_code == OP_MASK_EXT_IM) ||
              (op_code == OP_XOR_EXT_ER) || (op_code == OP_XOR_EXT_IM);
    fetch_len = is_ext ? 3'(EXT_FETCH) : 3'h0; // RULE_02
  end

  ltf_alu u_alu (
    .dst_val  (op_dst),
    .src_val  (op_src),
    .do_xor   (is_xor),
    .result   (alu_res),
    .res_zero (alu_z),
    .res_sign (alu_s)
  );

  // Only C, V, Z, S reach the jump condition; D, H and user bits do not
  always_comb begin
    case (cond_sel)
      CC_C:    cond_true = status_ff[FLG_C - FLG_H]; // RULE_09
      CC_Z:    cond_true = status_ff[FLG_Z - FLG_H]; // RULE_09
      CC_S:    cond_true = status_ff[FLG_S - FLG_H]; // RULE_09
      CC_V:    cond_true = status_ff[FLG_V - FLG_H]; // RULE_09
      default: cond_true = 1'b0; // RULE_10 RULE_12
    endcase
  end

  always_comb begin
    nxt_status = status_ff;
    nxt_user   = user_ff;
    nxt_sp     = sp_ff;
    nxt_pc_sv  = pc_sv_ff;
    nxt_vec    = vec_ff;
    nxt_vlo    = vlo_ff;
    nxt_tcnt   = tcnt_ff;
    nxt_st     = st_ff;
    nxt_wb     = wb_ff;
    nxt_wbe    = 1'b0;
    mem_we     = 1'b0;
    mem_re     = 1'b0;
    mem_addr   = sp_ff;
    mem_wdata  = 8'h00;
    pc_load    = 1'b0;
    pc_next    = pc_sv_ff;
    if (user_flag_we) begin
      nxt_user = user_flag_val; // RULE_11
    end
    case (st_ff)
      LTF_IDLE: begin
        nxt_tcnt = TS_ZERO;
        if (irq_take || illegal_take || (op_valid && op_code == OP_TRAP)) begin
          nxt_sp    = sp_ff - SP_STEP_PC; // RULE_05
          nxt_pc_sv = pc_in;
          nxt_vec   = vec_addr;
          nxt_st    = LTF_PUSH_LO;
        end else if (op_valid && op_code == OP_INT_RETURN) begin
          nxt_st = LTF_POP_FL;
        end else if (op_valid && (is_mask || is_xor)) begin
          nxt_status[FLG_Z - FLG_H] = alu_z; // RULE_01 RULE_03
          nxt_status[FLG_S - FLG_H] = alu_s; // RULE_01 RULE_03
          nxt_status[FLG_V - FLG_H] = 1'b0; // RULE_01 RULE_02 RULE_03 RULE_04
          if (is_xor) begin
            nxt_wb  = alu_res; // RULE_03 RULE_04
            nxt_wbe = 1'b1;
          end
        end else if (alu_flag_we) begin
          nxt_status = alu_flag_val; // RULE_07 RULE_08
        end
      end
      LTF_PUSH_LO: begin
        mem_we    = 1'b1;
        mem_addr  = sp_ff + SP_STEP_ONE;
        mem_wdata = pc_sv_ff[7:0]; // RULE_05
        nxt_tcnt  = tcnt_ff + 3'h1;
        nxt_st    = LTF_PUSH_HI;
      end
      LTF_PUSH_HI: begin
        mem_we    = 1'b1;
        mem_wdata = pc_sv_ff[15:8]; // RULE_05
        nxt_sp    = sp_ff - SP_STEP_FL; // RULE_06
        nxt_tcnt  = tcnt_ff + 3'h1;
        nxt_st    = LTF_PUSH_FL;
      end
      LTF_PUSH_FL: begin
        mem_we    = 1'b1;
        mem_wdata = flags; // RULE_06 RULE_14
        nxt_tcnt  = tcnt_ff + 3'h1;
        nxt_st    = LTF_VEC_HI;
      end
      LTF_VEC_HI: begin
        mem_re   = 1'b1;
        mem_addr = vec_ff;
        nxt_tcnt = tcnt_ff + 3'h1;
        nxt_st   = LTF_VEC_LO;
      end
      LTF_VEC_LO: begin
        // Vector word read high byte first; one cycle of memory latency assumed
        mem_re   = 1'b1;
        mem_addr = vec_ff + SP_STEP_ONE;
        if (tcnt_ff == TS_LAST - 3'h1) begin
          nxt_vlo  = mem_rdata;
          nxt_tcnt = tcnt_ff + 3'h1;
        end else begin
          pc_load  = 1'b1;
          pc_next  = {vlo_ff, mem_rdata}; // RULE_06
          nxt_st   = LTF_IDLE;
        end
      end
      LTF_POP_FL: begin
        mem_re   = 1'b1;
        if (tcnt_ff == TS_ZERO) begin
          nxt_tcnt = tcnt_ff + 3'h1;
        end else begin
          nxt_status = mem_rdata[FLG_C:FLG_H]; // RULE_15
          nxt_user   = mem_rdata[FLG_U2:FLG_U1]; // RULE_15
          nxt_sp     = sp_ff + SP_STEP_ONE;
          nxt_st     = LTF_IDLE;
        end
      end
      default: nxt_st = LTF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_ff <= STATUS_RST;
      sp_ff     <= 16'h0000;
      pc_sv_ff  <= 16'h0000;
      vec_ff    <= 16'h0000;
      vlo_ff    <= 8'h00;
      tcnt_ff   <= TS_ZERO;
      st_ff     <= LTF_IDLE;
      wb_ff     <= 8'h00;
      wbe_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      sp_ff     <= nxt_sp;
      pc_sv_ff  <= nxt_pc_sv;
      vec_ff    <= nxt_vec;
      vlo_ff    <= nxt_vlo;
      tcnt_ff   <= nxt_tcnt;
      st_ff     <= nxt_st;
      wb_ff     <= nxt_wb;
      wbe_ff    <= nxt_wbe;
    end
  end

  // User bits sit outside the reset on purpose
  always_ff @(posedge core_clk) begin
    user_ff <= nxt_user; // RULE_13
  end
endmodule
`default_nettype wire

// ---- test/ltf_monitor.sv ----
// Concurrent checks on the slice ports
`timescale 1ns/1ps
`default_nettype none
module ltf_monitor
  import ltf_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic        irq_take,
  input wire logic        illegal_take,
  input wire logic        alu_flag_we,
  input wire logic        user_flag_we,
  input wire logic        busy,
  input wire logic        wb_en,
  input wire logic        mem_we,
  input wire logic        pc_load,
  input wire logic        cond_true,
  input wire logic [7:0]  op_code,
  input wire logic [7:0]  op_dst,
  input wire logic [7:0]  op_src,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  wb_data,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  flags,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] sp_out,
  input wire logic [15:0] pc_in,
  input wire logic [5:0]  alu_flag_val,
  input wire logic [3:0]  cond_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Traps outrank opcodes, so plain issues exclude them
  wire logic       idle = !busy && !irq_take && !illegal_take;
  wire logic       go   = idle && op_valid;
  wire logic       trap = !busy && (irq_take || illegal_take || op_valid && op_code == OP_TRAP);
  wire logic [7:0] a_r  = op_dst & op_src;
  wire logic [7:0] x_r  = op_dst ^ op_src;
  chk_mask_flags: assert property (go && op_code inside {[OP_MASK_FIRST:OP_MASK_EXT_IM]} |=>
    !wb_en && flags[6:4] == {~|$past(a_r), $past(a_r[7]), 1'b0}) else $error("mask test flags");
  chk_xor_result: assert property (go && op_code inside {[OP_XOR_FIRST:OP_XOR_EXT_IM]} |=>
    wb_en && wb_data == $past(x_r) && flags[6:4] == {~|$past(x_r), $past(x_r[7]), 1'b0}
    && $stable({flags[7], flags[3:2]})) else $error("xor result");
  chk_trap_push: assert property (trap |=>
    mem_we && mem_addr == $past(sp_out) - 16'h0001 && mem_wdata == $past(pc_in[7:0])
    ##1 mem_we && mem_addr == $past(sp_out, 2) - 16'h0002 && mem_wdata == $past(pc_in[15:8], 2)
    ##1 mem_we && mem_addr == $past(sp_out, 3) - 16'h0003 && mem_wdata == flags) else $error("trap push");
  chk_trap_time: assert property (trap |->
    ##4 sp_out == $past(sp_out, 4) - 16'h0003 ##[1:2] pc_load) else $error("trap timing");
  chk_trap_flags: assert property (trap && !user_flag_we |=>
    $stable(flags[7:2]) [*5]) else $error("trap flags");
  chk_return_pop: assert property (go && op_code == OP_INT_RETURN |->
    ##3 flags == $past(mem_rdata) && sp_out == $past(sp_out, 3) + 16'h0001) else $error("return pop");
  chk_alu_flags: assert property (idle && !op_valid && alu_flag_we && !user_flag_we |=>
    flags[7:2] == $past(alu_flag_val) && $stable(flags[1:0])) else $error("flag update");
  chk_cond_sel: assert property (
    cond_true == (cond_sel[3:2] == 2'b01 && flags[cond_sel[2:0]])) else $error("condition select");
  cover property (trap);
  cover property (go && op_code == OP_INT_RETURN);
  cover property (wb_en);
  cover property (pc_load);
endmodule
bind ltf_core ltf_monitor u_ltf_monitor (
  .core_clk     (core_clk),
  .rst          (rst),
  .op_valid     (op_valid),
  .irq_take     (irq_take),
  .illegal_take (illegal_take),
  .alu_flag_we  (alu_flag_we),
  .user_flag_we (user_flag_we),
  .busy         (busy),
  .wb_en        (wb_en),
  .mem_we       (mem_we),
  .pc_load      (pc_load),
  .cond_true    (cond_true),
  .op_code      (op_code),
  .op_dst       (op_dst),
  .op_src       (op_src),
  .mem_rdata    (mem_rdata),
  .wb_data      (wb_data),
  .mem_wdata    (mem_wdata),
  .flags        (flags),
  .mem_addr     (mem_addr),
  .sp_out       (sp_out),
  .pc_in        (pc_in),
  .alu_flag_val (alu_flag_val),
  .cond_sel     (cond_sel)
);
`default_nettype wire

// ---- test/ltf_stack_model.sv ----
// Stack and vector memory beside the slice
`timescale 1ns/1ps
`default_nettype none
module ltf_stack_model (
  input  wire logic        core_clk,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata
);
  logic [7:0] mem [logic [15:0]];
  initial mem_rdata = 8'h00;
  // Idle cycles invert the data so a late sample never sees a stale byte
  always @(posedge core_clk) begin
    if (mem_we) mem[mem_addr] = mem_wdata;
    if (!mem_re) mem_rdata <= ~mem_rdata;
    else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : mem_addr[7:0] ^ 8'h5A;
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the logic, trap and flags slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ltf_pkg::*;
  logic        core_clk, rst, op_valid, irq_take, illegal_take, alu_flag_we, user_flag_we, busy, wb_en;
  logic        mem_we, mem_re, pc_load, cond_true;
  logic [7:0]  op_code, op_dst, op_src, mem_rdata, wb_data, mem_wdata, flags, d, s, f;
  logic [15:0] pc_in, vec_addr, mem_addr, sp_out, pc_next, sp0;
  logic [5:0]  alu_flag_val;
  logic [3:0]  cond_sel;
  logic [2:0]  fetch_len;
  logic [1:0]  user_flag_val;
  logic [15:0] exp_q [$];
  int          bad_count = 0;
  int          comparisons = 0;
  ltf_core u_ltf_core (
    .core_clk      (core_clk),
    .rst           (rst),
    .op_valid      (op_valid),
    .op_code       (op_code),
    .op_dst        (op_dst),
    .op_src        (op_src),
    .irq_take      (irq_take),
    .illegal_take  (illegal_take),
    .pc_in         (pc_in),
    .vec_addr      (vec_addr),
    .alu_flag_we   (alu_flag_we),
    .alu_flag_val  (alu_flag_val),
    .user_flag_we  (user_flag_we),
    .user_flag_val (user_flag_val),
    .cond_sel      (cond_sel),
    .mem_rdata     (mem_rdata),
    .busy          (busy),
    .wb_data       (wb_data),
    .wb_en         (wb_en),
    .fetch_len     (fetch_len),
    .mem_we        (mem_we),
    .mem_re        (mem_re),
    .mem_addr      (mem_addr),
    .mem_wdata     (mem_wdata),
    .sp_out        (sp_out),
    .pc_load       (pc_load),
    .pc_next       (pc_next),
    .flags         (flags),
    .cond_true     (cond_true)
  );
  ltf_stack_model u_ltf_stack_model (
    .core_clk  (core_clk),
    .mem_we    (mem_we),
    .mem_re    (mem_re),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );
  always #20 core_clk = ~core_clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic issue(input logic [1:0] t, input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    {op_valid, irq_take, illegal_take, op_code, op_dst, op_src} <= {t == 2'b00, t, op, a, b};
    @(posedge core_clk);
    {op_valid, irq_take, illegal_take} <= 3'b000;
    @(negedge core_clk);
    for (int i = 0; i < 12 && busy !== 1'b0; i++) @(negedge core_clk);
  endtask
  task automatic setf(input logic [1:0] e, input logic [5:0] a, input logic [1:0] u);
    @(posedge core_clk);
    {alu_flag_we, alu_flag_val, user_flag_we, user_flag_val} <= {e[1], a, e[0], u};
    @(posedge core_clk);
    {alu_flag_we, user_flag_we} <= 2'b00;
    @(negedge core_clk);
  endtask
  // Results are matched in issue order; a missing pulse shows up as a later misfit
  always @(posedge core_clk) begin
    if (wb_en === 1'b1) check({5'h00, flags[6:4], wb_data}, exp_q.pop_front());
    if (pc_load === 1'b1) check(pc_next, exp_q.pop_front());
  end
  initial begin
    {core_clk, op_valid, irq_take, illegal_take, alu_flag_we, user_flag_we, cond_sel} = '0;
    {op_code, op_dst, op_src, pc_in, vec_addr, alu_flag_val, user_flag_val} = '0;
    rst = 1'b1;
    void'($urandom(73209));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    f = {6'h00, 2'($urandom)};
    setf(2'b01, 6'h00, f[1:0]);
    check(16'(flags), 16'(f));
    f[7:2] = 6'($urandom);
    setf(2'b10, f[7:2], ~f[1:0]);
    check(16'(flags), 16'(f));
    for (int o = 8'h72; o <= 8'hB9; o++) begin
      if (o > 8'h79 && o < 8'hB2) continue;
      d = 8'($urandom);
      // Odd opcodes force a zero result to hit the zero flag
      s = !o[0] ? 8'($urandom) : (o < 8'hB2) ? ~d : d;
      f[6:4] = (o < 8'hB2) ? {(d & s) == 8'h00, d[7] & s[7], 1'b0} : {d == s, d[7] ^ s[7], 1'b0};
      if (o >= 8'hB2) exp_q.push_back({5'h00, f[6:4], d ^ s});
      issue(2'b00, 8'(o), d, s);
      check(16'(flags), 16'(f));
      // Opcode still stands after the issue, so the fetch length can be read back here
      check(16'(fetch_len), (8'(o) inside {OP_MASK_EXT_ER, OP_MASK_EXT_IM, OP_XOR_EXT_ER, OP_XOR_EXT_IM}) ?
            16'(EXT_FETCH) : 16'h0000);
    end
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk);
      cond_sel <= 4'(c);
      @(negedge core_clk);
      check(16'(cond_true), 16'(c >= 4 && c <= 7 && f[c[2:0]]));
    end
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      @(posedge core_clk);
      {pc_in, vec_addr} <= {16'($urandom), 8'h10, d};
      sp0 = sp_out;
      exp_q.push_back({d ^ 8'h5A, (d + 8'h01) ^ 8'h5A});
      issue(k == 0 ? 2'b00 : k == 1 ? 2'b10 : 2'b01, OP_TRAP, 8'h00, 8'h00);
      check(sp_out, sp0 - 16'h0003);
      check(16'(flags), 16'(f));
      setf(2'b10, ~f[7:2], f[1:0]);
      issue(2'b00, OP_INT_RETURN, 8'h00, 8'h00);
      @(negedge core_clk);
      check(16'(flags), 16'(f));
    end
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check(16'(flags), {14'h0000, f[1:0]});
    print_verdict();
  end
  initial begin
    #50us;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
